// >>> design/adcc_top.sv
// What this block does
// (R1) bits 7..6 pick conversion clock source
// (R2) bits 5..3 route analog input 0..4
// (R3) writing start flag begins a conversion
// (R4) start flag reads 1 while converting
// (R5) hardware clears start flag on completion
// (R6) bit 1 reads zero, writes ignored
// (R7) power bit enables the converter
// (R8) powered off: converter idle, no start
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter side
  input wire logic internal_rc_clock_i,
  output logic [2:0] input_channel_select_o,
  output logic converter_power_on_o,
  output logic sample_o,
  output logic conv_done_o
);
  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // --------------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------------
  adcc_pkg::adcc_ctrl_s ctrl;
  adcc_pkg::adcc_state_e state;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic [3:0] tick_cnt;
  logic tick;
  logic wr_ctrl;
  logic start;
  logic finish;
  logic [7:0] ctrl_byte;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend <= hsel && htrans == adcc_pkg::HTRANS_NONSEQ && hwrite;
      wr_addr <= haddr;
    end
  end

  assign ctrl_byte = {ctrl.conv_clock_select, ctrl.input_channel_select, ctrl.go_busy,
                      1'b0, ctrl.converter_power_on}; // R6

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans == adcc_pkg::HTRANS_NONSEQ && !hwrite) begin
      case (haddr)
        adcc_pkg::ADC_CONTROL_ADDR: hrdata <= {24'h00_0000, ctrl_byte}; // R4
        adcc_pkg::ADC_STATUS_ADDR: hrdata <= {31'h0000_0000, state == adcc_pkg::ADCC_CONVERT};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign wr_ctrl = wr_pend && wr_addr == adcc_pkg::ADC_CONTROL_ADDR;
  // start needs the power bit set in the same write, and an idle sequencer
  assign start = wr_ctrl && hwdata[adcc_pkg::GO_BIT] && hwdata[adcc_pkg::POWER_BIT]
                 && state == adcc_pkg::ADCC_IDLE; // R3 R8
  assign finish = state == adcc_pkg::ADCC_CONVERT && tick
                  && tick_cnt == adcc_pkg::CONV_TICKS - 4'h1;

  // --------------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= adcc_pkg::adcc_ctrl_s'({adcc_pkg::ADC_CONTROL_RESET[7:2],
                                     adcc_pkg::ADC_CONTROL_RESET[0]});
    end else begin
      if (wr_ctrl && state == adcc_pkg::ADCC_IDLE) begin
        ctrl.conv_clock_select <= hwdata[adcc_pkg::CLK_SEL_HI:adcc_pkg::CLK_SEL_LO]; // R1
        ctrl.input_channel_select <= hwdata[adcc_pkg::CHAN_HI:adcc_pkg::CHAN_LO]; // R2
      end
      if (wr_ctrl) begin
        ctrl.converter_power_on <= hwdata[adcc_pkg::POWER_BIT]; // R7
      end
      if (start) begin
        ctrl.go_busy <= 1'b1; // R3
      end else if (finish || !ctrl.converter_power_on
                   || (wr_ctrl && !hwdata[adcc_pkg::POWER_BIT])) begin
        ctrl.go_busy <= 1'b0; // R5 R8
      end
    end
  end

  // --------------------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= adcc_pkg::ADCC_IDLE;
    end else begin
      case (state)
        adcc_pkg::ADCC_IDLE: if (start) state <= adcc_pkg::ADCC_CONVERT; // R3
        adcc_pkg::ADCC_CONVERT: begin
          if (finish || (wr_ctrl && !hwdata[adcc_pkg::POWER_BIT])) begin
            state <= adcc_pkg::ADCC_IDLE; // R5 R8
          end
        end
        default: state <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 4'h0;
    end else if (state != adcc_pkg::ADCC_CONVERT) begin
      tick_cnt <= 4'h0;
    end else if (tick) begin
      tick_cnt <= tick_cnt + 4'h1;
    end
  end

  adcc_tick u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .run_i(state == adcc_pkg::ADCC_CONVERT),
    .sel_i(ctrl.conv_clock_select),
    .internal_rc_clock_i(internal_rc_clock_i),
    .tick_o(tick)
  );

  // --------------------------------------------------------------------------
  // converter outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      input_channel_select_o <= 3'h0;
      converter_power_on_o <= 1'b0;
      sample_o <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      input_channel_select_o <= (ctrl.input_channel_select > adcc_pkg::CHAN_MAX)
                                ? adcc_pkg::CHAN_MAX : ctrl.input_channel_select; // R2
      converter_power_on_o <= ctrl.converter_power_on; // R7
      sample_o <= start;
      conv_done_o <= finish; // R5
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  busy_tracks_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R4
    ctrl.go_busy == (state == adcc_pkg::ADCC_CONVERT))
    else $error("busy flag disagrees with conversion state");
  start_sets_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R3
    start |=> ctrl.go_busy && state == adcc_pkg::ADCC_CONVERT)
    else $error("start did not launch conversion");
  finish_clears_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R5
    finish |=> !ctrl.go_busy ##0 conv_done_o)
    else $error("busy not cleared on completion");
  off_no_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R8
    !ctrl.converter_power_on && !wr_ctrl |=> state == adcc_pkg::ADCC_IDLE)
    else $error("conversion while powered off");
  bit1_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R6
    hrdata[adcc_pkg::UNUSED_BIT] == 1'b0)
    else $error("unused bit not zero");
  power_follows_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R7
    wr_ctrl |=> ##1 converter_power_on_o == $past(hwdata[adcc_pkg::POWER_BIT], 2))
    else $error("power output did not follow write");
  div2_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R1
    start && hwdata[adcc_pkg::CLK_SEL_HI:adcc_pkg::CLK_SEL_LO] == adcc_pkg::CLK_DIV2
    |=> ##21 finish)
    else $error("div2 conversion length wrong");
  chan_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) // R2
    state == adcc_pkg::ADCC_CONVERT ##1 state == adcc_pkg::ADCC_CONVERT
    |-> $stable(ctrl.input_channel_select))
    else $error("channel changed mid conversion");
endmodule : adcc_top
`default_nettype wire

// >>> design/adcc_pkg.sv
package adcc_pkg;
  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [31:0] ADC_CONTROL_ADDR = 32'h0000_0000;
  localparam logic [31:0] ADC_STATUS_ADDR = 32'h0000_0004;
  localparam logic [7:0] ADC_CONTROL_RESET = 8'h00;
  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int CLK_SEL_HI = 7;
  localparam int CLK_SEL_LO = 6;
  localparam int CHAN_HI = 5;
  localparam int CHAN_LO = 3;
  localparam int GO_BIT = 2;
  localparam int UNUSED_BIT = 1;
  localparam int POWER_BIT = 0;
  // --------------------------------------------------------------------------
  // clock selection codes and channel limit
  // --------------------------------------------------------------------------
  localparam logic [1:0] CLK_DIV2 = 2'h0;
  localparam logic [1:0] CLK_DIV8 = 2'h1;
  localparam logic [1:0] CLK_DIV32 = 2'h2;
  localparam logic [1:0] CLK_RC = 2'h3;
  localparam logic [2:0] CHAN_MAX = 3'h4;
  // --------------------------------------------------------------------------
  // timing and bus transfer code
  // --------------------------------------------------------------------------
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  // conversion length in conversion-clock periods (11: 10 bits plus sampling)
  localparam logic [3:0] CONV_TICKS = 4'hB;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [1:0] conv_clock_select;
    logic [2:0] input_channel_select;
    logic go_busy;
    logic converter_power_on;
  } adcc_ctrl_s;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_CONVERT
  } adcc_state_e;
endpackage : adcc_pkg

// >>> design/adcc_tick.sv
`timescale 1ns/1ps
`default_nettype none
// conversion clock tick generator
module adcc_tick (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // control
  input wire logic run_i,
  input wire logic [1:0] sel_i,
  input wire logic internal_rc_clock_i,
  // tick
  output logic tick_o
);
  logic [4:0] div_cnt;
  logic [4:0] last;
  logic rc_s1;
  logic rc_s2;
  logic rc_s3;

  always_comb begin
    case (sel_i)
      adcc_pkg::CLK_DIV2: last = adcc_pkg::DIV2_LAST;
      adcc_pkg::CLK_DIV8: last = adcc_pkg::DIV8_LAST;
      default: last = adcc_pkg::DIV32_LAST;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end else begin
      rc_s1 <= internal_rc_clock_i;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 5'h00;
    end else if (!run_i || div_cnt == last) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // system divisions or a rising edge of the internal RC clock
  assign tick_o = run_i && ((sel_i == adcc_pkg::CLK_RC) ? (rc_s2 && !rc_s3)
                                                          : (div_cnt == last)); // R1
endmodule : adcc_tick
`default_nettype wire

// >>> dv/adcc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module test_adcc_top;
  // --------------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic internal_rc_clock_i = 1'b0;
  wire logic hready;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [2:0] input_channel_select_o;
  wire logic converter_power_on_o;
  wire logic sample_o;
  wire logic conv_done_o;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic rd_dp = 1'b0;
  logic sample_seen = 1'b0;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  assign hready = hreadyout;
  adcc_top i_adcc_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .internal_rc_clock_i(internal_rc_clock_i), .input_channel_select_o(input_channel_select_o),
    .converter_power_on_o(converter_power_on_o), .sample_o(sample_o), .conv_done_o(conv_done_o));
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    forever #100 internal_rc_clock_i = ~internal_rc_clock_i;
  end
  // --------------------------------------------------------------------------
  // checking
  // --------------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (exp !== got) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // read data is compared against the oldest note at the end of each read data phase
  always @(posedge clk_sys_i) begin
    cyc++;
    if (sample_o === 1'b1) begin
      sample_seen = 1'b1;
    end
    if (rd_dp && hready) begin
      note = notes.pop_front();
      chk($sformatf("hrdata at %h", note[63:32]), note[31:0], hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    rd_dp <= hsel && htrans == adcc_pkg::HTRANS_NONSEQ && !hwrite && hready;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  // --------------------------------------------------------------------------
  // bus master
  // --------------------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (!w) begin
      notes.push_back({a, d});
    end
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= adcc_pkg::HTRANS_NONSEQ;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    htrans <= 2'h0;
    hwdata <= w ? d : $urandom();
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
  endtask : bus
  // --------------------------------------------------------------------------
  // conversion with one clock selection
  // --------------------------------------------------------------------------
  task automatic conv(input logic [1:0] sel, input int per);
    logic [2:0] ch;
    logic [7:0] c;
    realtime t0;
    int n;
    ch = 3'($urandom_range(4, 0));
    c = {sel, ch, 3'b111};
    sample_seen = 1'b0;
    bus(1'b1, adcc_pkg::ADC_CONTROL_ADDR, {24'h0, c});
    t0 = $realtime;
    // outputs are registered one edge after the control register
    repeat (2) @(posedge clk_sys_i);
    chk("channel out", {29'h0, ch}, {29'h0, input_channel_select_o});
    chk("power out", 32'h1, {31'h0, converter_power_on_o});
    bus(1'b0, adcc_pkg::ADC_CONTROL_ADDR, {24'h0, c & 8'hFD});
    bus(1'b0, adcc_pkg::ADC_STATUS_ADDR, 32'h1);
    n = 0;
    while (conv_done_o !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    n = int'(($realtime - t0) / 25.0);
    if (sel == adcc_pkg::CLK_RC) begin
      chk("rc conversion length", 32'h1, {31'h0, n >= 11 * per - 11 && n <= 11 * per + 8});
    end else begin
      chk("conversion length", 11 * per + 1, n);
    end
    chk("sample pulse", 32'h1, {31'h0, sample_seen});
    bus(1'b0, adcc_pkg::ADC_CONTROL_ADDR, {24'h0, c & 8'hF9});
    bus(1'b0, adcc_pkg::ADC_STATUS_ADDR, 32'h0);
  endtask : conv
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(5));
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    bus(1'b0, adcc_pkg::ADC_CONTROL_ADDR, {24'h0, adcc_pkg::ADC_CONTROL_RESET});
    bus(1'b0, adcc_pkg::ADC_STATUS_ADDR, 32'h0);
    bus(1'b0, 32'h0000_0008, 32'h0);
    bus(1'b1, 32'h0000_0008, $urandom());
    bus(1'b1, adcc_pkg::ADC_CONTROL_ADDR, 32'hFFFF_FFFE);
    bus(1'b0, adcc_pkg::ADC_CONTROL_ADDR, 32'h0000_00F8);
    bus(1'b0, adcc_pkg::ADC_STATUS_ADDR, 32'h0);
    repeat (40) @(posedge clk_sys_i);
    chk("power off idle", 32'h0, {31'h0, converter_power_on_o});
    chk("channel clamp", {29'h0, adcc_pkg::CHAN_MAX}, {29'h0, input_channel_select_o});
    conv(adcc_pkg::CLK_DIV2, 2);
    conv(adcc_pkg::CLK_DIV8, 8);
    conv(adcc_pkg::CLK_DIV32, 32);
    conv(adcc_pkg::CLK_RC, 8);
    bus(1'b1, adcc_pkg::ADC_CONTROL_ADDR, 32'h0000_0087);
    bus(1'b1, adcc_pkg::ADC_CONTROL_ADDR, 32'h0000_0086);
    bus(1'b0, adcc_pkg::ADC_STATUS_ADDR, 32'h0);
    repeat (4) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule : test_adcc_top
`default_nettype wire
